// ==== shared/ess_pkg.sv ====
// constants of the edge source select and edge status block
// assumes a 32-bit apb slave with one aligned word per register
`default_nettype none
package ess_pkg;
   // byte offsets
   localparam logic [11:0] ESS_OFF_CTRL2 = 12'h000;
   localparam logic [11:0] ESS_OFF_GATE = 12'h004;
   localparam logic [11:0] ESS_OFF_IRQ_STAT = 12'h008;
   localparam logic [11:0] ESS_OFF_IRQ_MASK = 12'h00C;
   // edge_control_two field positions
   localparam int ESS_B_E1_MODE = 15;
   localparam int ESS_B_E1_POL = 14;
   localparam int ESS_B_E1_SEL_HI = 13;
   localparam int ESS_B_E1_SEL_LO = 10;
   localparam int ESS_B_E2_FLAG = 9;
   localparam int ESS_B_E1_FLAG = 8;
   localparam int ESS_B_E2_MODE = 7;
   localparam int ESS_B_E2_POL = 6;
   // gate register field positions
   localparam int ESS_B_PASS_EN = 0;
   localparam int ESS_B_SEQ_EN = 1;
   // event bits in the interrupt status and mask registers
   localparam int ESS_B_EV1 = 0;
   localparam int ESS_B_EV2 = 1;
   // reset values
   localparam logic [3:0] ESS_RST_SEL = 4'h0;
   localparam logic [1:0] ESS_RST_EV = 2'h0;
   // first edge source codes
   localparam logic [3:0] ESS_SEL_TIMER1 = 4'h0;
   localparam logic [3:0] ESS_SEL_CMP_OUT1 = 4'h1;
   localparam logic [3:0] ESS_SEL_PIN2 = 4'h2;
   localparam logic [3:0] ESS_SEL_PIN1 = 4'h3;
   localparam logic [3:0] ESS_SEL_PIN3 = 4'h4;
   localparam logic [3:0] ESS_SEL_PIN4 = 4'h5;
   localparam logic [3:0] ESS_SEL_PIN5 = 4'h6;
   localparam logic [3:0] ESS_SEL_PIN6 = 4'h7;
   localparam logic [3:0] ESS_SEL_PIN7 = 4'h8;
   localparam logic [3:0] ESS_SEL_PIN8 = 4'h9;
   localparam logic [3:0] ESS_SEL_CAP1 = 4'hA;
   localparam logic [3:0] ESS_SEL_CAP2 = 4'hB;
   localparam logic [3:0] ESS_SEL_CAP3 = 4'hC;
   localparam logic [3:0] ESS_SEL_CMPR1 = 4'hD;
   localparam logic [3:0] ESS_SEL_CMPR2 = 4'hE;
   localparam logic [3:0] ESS_SEL_CMPR3 = 4'hF;
endpackage
`default_nettype wire

// ==== verilog/ess_source_mux.sv ====
// sixteen-way source selector for the first edge trigger
// assumes all sources are synchronous to pclk
`default_nettype none
module ess_source_mux
   import ess_pkg::*;
#(
   parameter bit SMALL_PACKAGE = 1'b0
)
(
   input wire logic [3:0] sel,
   input wire logic timer1_event,
   input wire logic compare_output_one,
   input wire logic [8:1] edge_pin,
   input wire logic [2:0] capture_channel,
   input wire logic [2:0] comparator_out,
   output logic src
);
   always_comb
   begin
      case (sel)
         ESS_SEL_TIMER1: src = timer1_event;
         ESS_SEL_CMP_OUT1: src = compare_output_one;
         ESS_SEL_PIN2: src = edge_pin[2];
         ESS_SEL_PIN1: src = edge_pin[1];
         ESS_SEL_PIN3: src = edge_pin[3];
         ESS_SEL_PIN4: src = edge_pin[4];
         ESS_SEL_PIN5: src = edge_pin[5];
         ESS_SEL_PIN6: src = edge_pin[6];
         // pin seven missing on small package
         ESS_SEL_PIN7: src = SMALL_PACKAGE ? 1'b0 : edge_pin[7];
         ESS_SEL_PIN8: src = edge_pin[8];
         ESS_SEL_CAP1: src = capture_channel[0];
         ESS_SEL_CAP2: src = capture_channel[1];
         ESS_SEL_CAP3: src = capture_channel[2];
         ESS_SEL_CMPR1: src = comparator_out[0];
         ESS_SEL_CMPR2: src = comparator_out[1];
         ESS_SEL_CMPR3: src = comparator_out[2];
         default: src = 1'b0;
      endcase
   end
endmodule
`default_nettype wire

// ==== verilog/ess_edge_detect.sv ====
// turns one source into an event: level or edge, chosen polarity
// assumes sig is synchronous to pclk
`default_nettype none
module ess_edge_detect
   import ess_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic sig,
   input wire logic edge_mode,
   input wire logic pol_high,
   output logic hit
);
   logic active;
   logic prev_active;

   assign active = pol_high ? sig : ~sig;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prev_active <= 1'b0;
      else
         prev_active <= active;
   end

   assign hit = edge_mode ? (active & ~prev_active) : active;
endmodule
`default_nettype wire

// ==== verilog/ess_edge_source_select_status.sv ====
// edge source select and edge status of the charge_time_unit,
// with apb register access and one level interrupt
// assumes edge sources and second_edge_in are synchronous to pclk
//
// How it works
// - codes 1111, 1110, 1101 pick comparator 3, 2, 1 as first edge.
// - codes 1100, 1011, 1010 pick capture channel 3, 2, 1.
// - code 1001 picks edge pin eight.
// - codes 0100, 0011, 0010 pick edge pins three, one and two.
// - code 0001 picks compare output one, 0000 the timer1 event.
// - bit 9 flags the second edge and a write drives the source.
// - bit 8 flags the first edge and a write drives the source.
// - the small package has no edge pin seven, so it reads as zero.
// - with sequencing on, the second edge waits for the first flag.
// - edges reach the flags only while the pass enable is set.
`default_nettype none
module ess_edge_source_select_status
   import ess_pkg::*;
#(
   parameter bit SMALL_PACKAGE = 1'b0
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic timer1_event,
   input wire logic compare_output_one,
   input wire logic [8:1] edge_pin,
   input wire logic [2:0] capture_channel,
   input wire logic [2:0] comparator_out,
   input wire logic second_edge_in,
   output logic first_edge_occurred_flag,
   output logic second_edge_occurred_flag,
   output logic current_source_on,
   output logic irq
);

////////////////////////////////////////////////////////////////////////
   logic [3:0] first_edge_source_select;
   logic first_edge_mode;
   logic first_edge_polarity;
   logic second_edge_sensitivity_mode;
   logic second_edge_polarity;
   logic edge_pass_enable;
   logic edge_sequence_enable;
   logic [1:0] irq_status;
   logic [1:0] irq_mask;
   logic edge1_src;
   logic [1:0] edge_src;
   logic [1:0] edge_mode;
   logic [1:0] edge_pol;
   logic [1:0] hit;
   logic [1:0] accept;
   logic setup;
   logic access;
   logic wr;
   logic mapped;
   logic wr_ctrl2;
   logic wr_gate;
   logic wr_stat;
   logic wr_mask;
   logic [31:0] next_rdata;

////////////////////////////////////////////////////////////////////////
// apb decode: zero wait states, error on unmapped offsets

   assign setup = psel & ~penable;
   assign access = psel & penable;
   assign wr = access & pwrite;
   assign mapped = (paddr == ESS_OFF_CTRL2) | (paddr == ESS_OFF_GATE) |
                   (paddr == ESS_OFF_IRQ_STAT) | (paddr == ESS_OFF_IRQ_MASK);
   assign wr_ctrl2 = wr & (paddr == ESS_OFF_CTRL2);
   assign wr_gate = wr & (paddr == ESS_OFF_GATE);
   assign wr_stat = wr & (paddr == ESS_OFF_IRQ_STAT);
   assign wr_mask = wr & (paddr == ESS_OFF_IRQ_MASK);
   assign pready = 1'b1;
   assign pslverr = access & ~mapped;

   always_comb
   begin
      next_rdata = 32'h0000_0000;
      case (paddr)
         ESS_OFF_CTRL2:
         begin
            next_rdata[ESS_B_E1_MODE] = first_edge_mode;
            next_rdata[ESS_B_E1_POL] = first_edge_polarity;
            next_rdata[ESS_B_E1_SEL_HI:ESS_B_E1_SEL_LO] =
               first_edge_source_select;
            next_rdata[ESS_B_E2_FLAG] = second_edge_occurred_flag;
            next_rdata[ESS_B_E1_FLAG] = first_edge_occurred_flag;
            next_rdata[ESS_B_E2_MODE] = second_edge_sensitivity_mode;
            next_rdata[ESS_B_E2_POL] = second_edge_polarity;
         end
         ESS_OFF_GATE:
         begin
            next_rdata[ESS_B_PASS_EN] = edge_pass_enable;
            next_rdata[ESS_B_SEQ_EN] = edge_sequence_enable;
         end
         ESS_OFF_IRQ_STAT: next_rdata[1:0] = irq_status;
         ESS_OFF_IRQ_MASK: next_rdata[1:0] = irq_mask;
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   // captured in setup so prdata comes from a flop in the access phase
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (setup && !pwrite)
         prdata <= next_rdata;
   end

////////////////////////////////////////////////////////////////////////
// configuration fields

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         first_edge_source_select <= ESS_RST_SEL;
         first_edge_mode <= 1'b0;
         first_edge_polarity <= 1'b0;
         second_edge_sensitivity_mode <= 1'b0;
         second_edge_polarity <= 1'b0;
      end
      else if (wr_ctrl2)
      begin
         first_edge_source_select <=
            pwdata[ESS_B_E1_SEL_HI:ESS_B_E1_SEL_LO];
         first_edge_mode <= pwdata[ESS_B_E1_MODE];
         first_edge_polarity <= pwdata[ESS_B_E1_POL];
         second_edge_sensitivity_mode <= pwdata[ESS_B_E2_MODE];
         second_edge_polarity <= pwdata[ESS_B_E2_POL];
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         edge_pass_enable <= 1'b0;
         edge_sequence_enable <= 1'b0;
      end
      else if (wr_gate)
      begin
         edge_pass_enable <= pwdata[ESS_B_PASS_EN];
         edge_sequence_enable <= pwdata[ESS_B_SEQ_EN];
      end
   end

////////////////////////////////////////////////////////////////////////
// source selection and event detection

   ess_source_mux #(
      .SMALL_PACKAGE(SMALL_PACKAGE)
   ) u_mux (
      .sel(first_edge_source_select),
      .timer1_event(timer1_event),
      .compare_output_one(compare_output_one),
      .edge_pin(edge_pin),
      .capture_channel(capture_channel),
      .comparator_out(comparator_out),
      .src(edge1_src)
   );

   assign edge_src = {second_edge_in, edge1_src};
   assign edge_mode = {second_edge_sensitivity_mode, first_edge_mode};
   assign edge_pol = {second_edge_polarity, first_edge_polarity};

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++)
      begin : g_det
         ess_edge_detect u_det (
            .pclk(pclk),
            .presetn(presetn),
            .sig(edge_src[gi]),
            .edge_mode(edge_mode[gi]),
            .pol_high(edge_pol[gi]),
            .hit(hit[gi])
         );
      end
   endgenerate

   assign accept[0] = hit[0] & edge_pass_enable;
   assign accept[1] = hit[1] & edge_pass_enable &
                      (~edge_sequence_enable | first_edge_occurred_flag);

////////////////////////////////////////////////////////////////////////
// edge status flags; a hardware edge wins over a software write

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         first_edge_occurred_flag <= 1'b0;
      else if (accept[0])
         first_edge_occurred_flag <= 1'b1;
      else if (wr_ctrl2)
         first_edge_occurred_flag <= pwdata[ESS_B_E1_FLAG];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         second_edge_occurred_flag <= 1'b0;
      else if (accept[1])
         second_edge_occurred_flag <= 1'b1;
      else if (wr_ctrl2)
         second_edge_occurred_flag <= pwdata[ESS_B_E2_FLAG];
   end

   // current source follows the two flags
   assign current_source_on = first_edge_occurred_flag ^
                              second_edge_occurred_flag;

////////////////////////////////////////////////////////////////////////
// interrupt: sticky events, write one to clear, set beats clear

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_status <= ESS_RST_EV;
      else
         irq_status <= accept | (irq_status & ~({2{wr_stat}} & pwdata[1:0]));
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_mask <= ESS_RST_EV;
      else if (wr_mask)
         irq_mask <= pwdata[1:0];
   end

   assign irq = |(irq_status & irq_mask);

////////////////////////////////////////////////////////////////////////
// checks

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_ctrl_write;
      wr_ctrl2;
   endsequence

   sequence s_quiet;
      !wr_ctrl2 && !accept[0] && !accept[1];
   endsequence

   property p_comp_sel;
      first_edge_source_select == ESS_SEL_CMPR3 |->
         edge1_src == comparator_out[2];
   endproperty
   a_comp_sel: assert property (p_comp_sel)
      else $error("comparator 3 not routed");

   property p_cap_sel;
      first_edge_source_select == ESS_SEL_CAP3 |->
         edge1_src == capture_channel[2];
   endproperty
   a_cap_sel: assert property (p_cap_sel)
      else $error("capture channel 3 not routed");

   property p_pin8_sel;
      first_edge_source_select == ESS_SEL_PIN8 |->
         edge1_src == edge_pin[8];
   endproperty
   a_pin8_sel: assert property (p_pin8_sel)
      else $error("edge pin eight not routed");

   property p_pin1_sel;
      first_edge_source_select == ESS_SEL_PIN1 |->
         edge1_src == edge_pin[1];
   endproperty
   a_pin1_sel: assert property (p_pin1_sel)
      else $error("edge pin one not routed");

   property p_timer_sel;
      first_edge_source_select == ESS_SEL_TIMER1 |->
         edge1_src == timer1_event;
   endproperty
   a_timer_sel: assert property (p_timer_sel)
      else $error("timer1 event not routed");

   property p_flag2_write;
      s_ctrl_write ##0 !accept[1] |=>
         second_edge_occurred_flag == $past(pwdata[ESS_B_E2_FLAG]);
   endproperty
   a_flag2_write: assert property (p_flag2_write)
      else $error("second flag write lost");

   property p_flag1_hold;
      s_quiet ##1 s_quiet |->
         $stable(first_edge_occurred_flag) &&
         $stable(current_source_on);
   endproperty
   a_flag1_hold: assert property (p_flag1_hold)
      else $error("first flag moved without cause");

   property p_pin7_absent;
      SMALL_PACKAGE && first_edge_source_select == ESS_SEL_PIN7 |->
         !edge1_src;
   endproperty
   a_pin7_absent: assert property (p_pin7_absent)
      else $error("pin seven seen on small package");

   property p_sequence;
      edge_sequence_enable && !first_edge_occurred_flag &&
      !second_edge_occurred_flag && !wr_ctrl2 |=>
         !second_edge_occurred_flag;
   endproperty
   a_sequence: assert property (p_sequence)
      else $error("second edge taken before first");

   property p_blocked;
      !edge_pass_enable && !wr_ctrl2 && !first_edge_occurred_flag |=>
         !first_edge_occurred_flag;
   endproperty
   a_blocked: assert property (p_blocked)
      else $error("edge passed while blocked");

   property p_level_mode;
      edge_pass_enable && !edge_sequence_enable &&
      !second_edge_sensitivity_mode &&
      second_edge_in == second_edge_polarity |=>
         second_edge_occurred_flag && irq_status[ESS_B_EV2];
   endproperty
   a_level_mode: assert property (p_level_mode)
      else $error("level sensitive second edge missed");

endmodule
`default_nettype wire

// ==== verif/ess_src_model.sv ====
// far-side model of the first edge sources (timer, compare, pins, etc.)
// assumes the bench changes code and fire just after a rising edge
`default_nettype none
module ess_src_model
   import ess_pkg::*;
(
   input wire logic [3:0] code,
   input wire logic fire,
   output logic timer1_event,
   output logic compare_output_one,
   output logic [8:1] edge_pin,
   output logic [2:0] capture_channel,
   output logic [2:0] comparator_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // unpicked sources show the inverse, so a wrong pick is seen
   always_comb
   begin
      timer1_event = ~fire;
      compare_output_one = ~fire;
      edge_pin = {8{~fire}};
      capture_channel = {3{~fire}};
      comparator_out = {3{~fire}};
      case (code)
         4'h0: timer1_event = fire;
         4'h1: compare_output_one = fire;
         4'h2: edge_pin[2] = fire;
         4'h3: edge_pin[1] = fire;
         4'h4: edge_pin[3] = fire;
         4'h5, 4'h6, 4'h7, 4'h8, 4'h9: edge_pin[code - 4'h1] = fire;
         4'hA, 4'hB, 4'hC: capture_channel[code - 4'hA] = fire;
         default: comparator_out[code - 4'hD] = fire;
      endcase
   end
endmodule
`default_nettype wire

// ==== verif/testbench.sv ====
// self-checking bench of the edge source select and status block
// assumes the source model in ess_src_model and an apb master here
`default_nettype none
module testbench
   import ess_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [3:0] code = 4'h0;
   logic fire = 1'b0;
   logic second_edge_in = 1'b0;
   wire logic [31:0] prdata;
   wire logic pready, pslverr, t1, oc1, f1, f2, cso, irq;
   wire logic [8:1] pins;
   wire logic [2:0] caps, cmps;
   logic [31:0] rd_data;
   logic rd_err;
   int fail_count = 0;
   int check_count = 0;
   int cycles = 0;
   always #4 pclk = ~pclk;
   // small package so the missing pin seven is exercised
   ess_edge_source_select_status #(.SMALL_PACKAGE(1'b1)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .timer1_event(t1),
      .compare_output_one(oc1), .edge_pin(pins),
      .capture_channel(caps), .comparator_out(cmps),
      .second_edge_in(second_edge_in), .first_edge_occurred_flag(f1),
      .second_edge_occurred_flag(f2), .current_source_on(cso),
      .irq(irq));
   ess_src_model partner (.code(code), .fire(fire), .timer1_event(t1),
      .compare_output_one(oc1), .edge_pin(pins),
      .capture_channel(caps), .comparator_out(cmps));
   ////////////////////////////////////////////////////////////////////
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge pclk)
   begin
      cycles <= cycles + 1;
      // ceiling well above the few hundred cycles the run needs
      if (cycles == 20000)
      begin
         fail_count = fail_count + 1;
         print_verdict();
      end
   end
   // settled values are compared at the falling edge
   task automatic check_word(input string name, input logic [31:0] exp,
      input logic [31:0] got);
      @(negedge pclk);
      check_count++;
      if (got !== exp)
      begin
         $display("wrong value %s expected %h seen %h", name, exp, got);
         fail_count++;
      end
      @(posedge pclk);
   endtask
   task automatic check_bit(input string name, input logic exp,
      input logic got);
      check_word(name, {31'h0000_0000, exp}, {31'h0000_0000, got});
   endtask
   // outputs read inside after the edge: 0 f1, 1 f2, 2 cso, 3 irq;
   // an argument taken at the launching edge would still be stale
   task automatic check_out(input string name, input logic exp,
      input int idx);
      logic [3:0] outs;
      @(negedge pclk);
      outs = {irq, cso, f2, f1};
      check_count++;
      if (outs[idx] !== exp)
      begin
         $display("wrong value %s expected %h seen %h", name, exp,
            outs[idx]);
         fail_count++;
      end
      @(posedge pclk);
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
      begin
         @(posedge pclk);
      end
      rd_data = prdata;
      rd_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // idle edge: a following call never reassigns psel in one step
      @(posedge pclk);
   endtask
   function automatic logic [31:0] ctrl(input logic [1:0] mp1,
      input logic [3:0] sel, input logic [1:0] f, input logic [1:0] mp2);
      return {16'h0000, mp1, sel, f, mp2, 6'h00};
   endfunction
   task automatic gate(input logic [31:0] g);
      apb(1'b1, ESS_OFF_GATE, g);
   endtask
   ////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      for (int i = 0; i < 4; i++)
      begin
         apb(1'b0, 12'(i * 4), 32'h0000_0000);
         check_word("reset value", 32'h0000_0000, rd_data);
      end
      check_out("current source", 1'b0, 2);
      check_bit("ready", 1'b1, pready);
      apb(1'b0, 12'h010, 32'h0000_0000);
      check_bit("unmapped error", 1'b1, rd_err);
      check_word("unmapped data", 32'h0000_0000, rd_data);
   endtask
   task automatic t_sources();
      for (int c = 0; c < 16; c++)
      begin
         fire <= 1'b0;
         code <= c[3:0];
         gate(32'h0000_0000);
         apb(1'b1, ESS_OFF_CTRL2, ctrl(2'h1, c[3:0], 2'h0, 2'h1));
         gate(32'h0000_0001);
         apb(1'b0, ESS_OFF_CTRL2, 32'h0000_0000);
         check_bit("idle source", 1'b0, rd_data[ESS_B_E1_FLAG]);
         fire <= 1'b1;
         repeat (2) @(posedge pclk);
         check_out("picked source", c != 8, 0);
      end
   endtask
   task automatic t_gate_irq();
      gate(32'h0000_0000);
      apb(1'b1, ESS_OFF_CTRL2, ctrl(2'h1, 4'hF, 2'h0, 2'h1));
      repeat (3) @(posedge pclk);
      check_out("blocked edge", 1'b0, 0);
      apb(1'b1, ESS_OFF_IRQ_MASK, 32'h0000_0001);
      gate(32'h0000_0001);
      check_out("passed edge", 1'b1, 0);
      check_out("irq raised", 1'b1, 3);
      fire <= 1'b0;
      apb(1'b1, ESS_OFF_IRQ_STAT, 32'h0000_0001);
      check_out("irq cleared", 1'b0, 3);
      apb(1'b1, ESS_OFF_IRQ_MASK, 32'h0000_0000);
      fire <= 1'b1;
      repeat (2) @(posedge pclk);
      check_out("irq masked", 1'b0, 3);
      apb(1'b0, ESS_OFF_IRQ_STAT, 32'h0000_0000);
      check_word("sticky status", 32'h0000_0001, rd_data);
   endtask
   task automatic t_seq();
      fire <= 1'b0;
      code <= 4'h0;
      gate(32'h0000_0000);
      apb(1'b1, ESS_OFF_CTRL2, ctrl(2'h1, 4'h0, 2'h0, 2'h1));
      second_edge_in <= 1'b1;
      gate(32'h0000_0003);
      repeat (3) @(posedge pclk);
      check_out("second waits", 1'b0, 1);
      fire <= 1'b1;
      repeat (3) @(posedge pclk);
      check_out("second after first", 1'b1, 1);
      check_out("source off", 1'b0, 2);
      fire <= 1'b0;
      gate(32'h0000_0000);
      apb(1'b1, ESS_OFF_CTRL2, ctrl(2'h1, 4'h0, 2'h0, 2'h1));
      gate(32'h0000_0001);
      check_out("second alone", 1'b1, 1);
      check_out("first absent", 1'b0, 0);
      check_out("source on", 1'b1, 2);
   endtask
   task automatic t_write();
      second_edge_in <= 1'b0;
      gate(32'h0000_0000);
      for (int f = 1; f < 4; f++)
      begin
         apb(1'b1, ESS_OFF_CTRL2, ctrl(2'h1, 4'h0, f[1:0], 2'h1));
         check_out("written first", f[0], 0);
         check_out("written second", f[1], 1);
         check_out("driven source", ^f[1:0], 2);
         apb(1'b0, ESS_OFF_CTRL2, 32'h0000_0000);
         check_word("ctrl readback", ctrl(2'h1, 4'h0, f[1:0], 2'h1),
            rd_data);
      end
   endtask
   task automatic t_mode();
      second_edge_in <= 1'b1;
      apb(1'b1, ESS_OFF_CTRL2, ctrl(2'h1, 4'h0, 2'h0, 2'h3));
      gate(32'h0000_0001);
      repeat (2) @(posedge pclk);
      check_out("steady high", 1'b0, 1);
      second_edge_in <= 1'b0;
      @(posedge pclk);
      second_edge_in <= 1'b1;
      repeat (2) @(posedge pclk);
      check_out("rising edge", 1'b1, 1);
      gate(32'h0000_0000);
      apb(1'b1, ESS_OFF_CTRL2, ctrl(2'h1, 4'h0, 2'h0, 2'h0));
      gate(32'h0000_0001);
      check_out("low inactive", 1'b0, 1);
      second_edge_in <= 1'b0;
      repeat (2) @(posedge pclk);
      check_out("low level", 1'b1, 1);
   endtask
   initial
   begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_sources();
      t_gate_irq();
      t_seq();
      t_write();
      t_mode();
      print_verdict();
   end
endmodule
`default_nettype wire
